// ---- verilog/hwi_pkg.sv ----
// Package with constants for the host word interface
package hwi_pkg;
  // Word geometry
  localparam int DATA_W = 18;
  localparam int BUF_W = 21;
  localparam int CB1_POS = 18;
  localparam int CB2_POS = 19;
  localparam int PAR_POS = 20;
  localparam int ADDR_W = 18;
  // Register byte offsets (APB)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_CODE_W = 4;
  localparam int CMD_IFC_BIT = 4;
  // Function command codes
  localparam logic [3:0] FC_CLR_ADDR = 4'h0;
  localparam logic [3:0] FC_RECEIVE = 4'h1;
  localparam logic [3:0] FC_TRANSMIT = 4'h2;
  localparam logic [3:0] FC_HOST_INT = 4'h9;
  // Status bits
  localparam int ST_NOT_BUSY = 0;
  localparam int ST_PARITY_OK = 1;
  localparam int ST_RX_MODE = 2;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PERR = 1;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Host handshake states
  typedef enum logic [1:0] {
    HWI_IDLE = 2'b00,
    HWI_REQ = 2'b01,
    HWI_WAIT = 2'b10
  } hwi_state_t;
endpackage

// ---- verilog/hwi_top.sv ----
// Host word interface: APB slave bridging processor words to host memory
//
// Added by the designer: the register addresses and the APB register port.
module hwi_top
  import hwi_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Host memory port
  output logic O_HOST_REQ,
  output logic O_HOST_WE,
  output logic [ADDR_W-1:0] O_HOST_ADDR,
  output logic [BUF_W-1:0] O_HOST_WDATA,
  input wire logic I_HOST_ACK,
  input wire logic [BUF_W-1:0] I_HOST_RDATA,
  output logic O_HOST_INT,
  // Interrupt
  output logic O_IRQ
);

  // Overview of the block:
  // - the processor side reaches the unit through seven APB registers
  // - an address write plays the load-address operation
  // - a command write carries the external and internal function commands
  // - a transmit data write packs the word and starts a host memory write
  // - a receive data read in receive mode starts the next host memory fetch
  // - one host transfer is in flight at a time; busy covers all of it
  // - software must poll not-busy before each data access
  // - a start while busy is not queued, so it may be lost
  // - the host side runs on its own timing, hence the synchronisers
  // - ack and read data share the same two-stage delay
  // - so the fetched word is settled when the synchronised ack is seen

  // Host-side inputs synchronised
  logic ack_s1_r, ack_s2_r;
  logic [BUF_W-1:0] rd_s1_r, rd_s2_r;

  // Word buffer shared by both directions
  logic [BUF_W-1:0] buf_r;
  // Host word address, pre-incremented on each start and on command 2
  logic [ADDR_W-1:0] addr_r;
  // Host transfer in progress
  logic busy_r;
  // Direction: high while fetching from the host
  logic rx_mode_r;
  // Parity result of the last fetched word
  logic par_ok_r;
  // Control bits packed above the data bits
  logic cb1_r;
  logic cb2_r;
  // Sticky event bits and their enables
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  // Host handshake state
  hwi_state_t st_r;
  hwi_state_t st_nxt;
  // Read data chosen during the setup cycle
  logic [31:0] prdata_nxt;

  // APB decode
  // Every access is one setup and one access cycle.
  // Effects land at the access edge, where ready is high.
  // Unmapped offsets only raise the error response.
  // Command field: low four bits the code, bit four internal.
  // Only codes 0, 1, 2 and 9 act as external commands.
  // Only internal code 1 acts; it clears the control bits.
  wire acc = I_PSEL & I_PENABLE & I_CE;
  wire wr = acc & I_PWRITE;
  wire rd = acc & ~I_PWRITE;
  wire hit_cmd = I_PADDR == OFF_CMD;
  wire hit_addr = I_PADDR == OFF_ADDR;
  wire hit_tx = I_PADDR == OFF_TXDATA;
  wire hit_rx = I_PADDR == OFF_RXDATA;
  wire hit_st = I_PADDR == OFF_STATUS;
  wire hit_is = I_PADDR == OFF_IRQ_STAT;
  wire hit_im = I_PADDR == OFF_IRQ_MASK;
  wire mapped = hit_cmd | hit_addr | hit_tx | hit_rx | hit_st | hit_is | hit_im;
  wire [3:0] code = I_PWDATA[CMD_CODE_LSB +: CMD_CODE_W];
  wire is_ifc = I_PWDATA[CMD_IFC_BIT];
  wire ext_cmd = wr & hit_cmd & ~is_ifc;
  wire cmd_rx = ext_cmd & (code == FC_RECEIVE);
  wire cmd_tx = ext_cmd & (code == FC_TRANSMIT);
  wire cmd_int = ext_cmd & (code == FC_HOST_INT);
  wire cmd_clr = ext_cmd & (code == FC_CLR_ADDR);
  wire ifc_clr = wr & hit_cmd & is_ifc & (code == FC_RECEIVE);
  wire tx_go = wr & hit_tx;
  wire rx_go = rd & hit_rx & rx_mode_r;
  wire start = cmd_rx | tx_go | rx_go;
  // Raise a new request only once the last ack has drained,
  // so a stale ack can never end the next transfer at once
  wire req_go = (st_r == HWI_REQ) & ~ack_s2_r;
  wire done = (st_r == HWI_WAIT) & ack_s2_r;
  wire rd_par = ^rd_s2_r;
  // word assembly with odd parity over data and control bits
  wire [BUF_W-1:0] tx_word = {~(^{cb2_r, cb1_r, I_PWDATA[DATA_W-1:0]}), cb2_r, cb1_r,
                              I_PWDATA[DATA_W-1:0]};
  wire [IRQ_W-1:0] irq_ev = {done & rx_mode_r & ~rd_par, done};

  // Read data mux
  // Built from the address of the setup cycle.
  // Registered at the setup edge, so it stands in the access cycle.
  // A receive read returns the word before the clear that it starts.
  // Unmapped and write-only offsets read as zero.
  always_comb begin
    prdata_nxt = RST_ZERO;
    if (hit_addr) prdata_nxt[ADDR_W-1:0] = addr_r;
    if (hit_rx) prdata_nxt[BUF_W-1:0] = buf_r;
    if (hit_st) begin
      prdata_nxt[ST_NOT_BUSY] = ~busy_r;
      prdata_nxt[ST_PARITY_OK] = par_ok_r;
      prdata_nxt[ST_RX_MODE] = rx_mode_r;
    end
    if (hit_is) prdata_nxt[IRQ_W-1:0] = irq_stat_r;
    if (hit_im) prdata_nxt[IRQ_W-1:0] = irq_mask_r;
  end

  // Host handshake sequencer
  // IDLE waits for a start, REQ waits for the old ack to fall,
  // WAIT holds the request until the synchronised ack arrives.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HWI_IDLE: if (start) st_nxt = HWI_REQ;
      HWI_REQ: if (req_go) st_nxt = HWI_WAIT;
      HWI_WAIT: if (ack_s2_r) st_nxt = HWI_IDLE;
      default: st_nxt = HWI_IDLE;
    endcase
  end

  // Input synchronisers
  // Two stages on every host-side input.
  // Read data is held by the host while ack is high,
  // so the word is stable by the time the second stage is used.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      rd_s1_r <= '0;
      rd_s2_r <= '0;
    end else if (I_CE) begin
      ack_s1_r <= I_HOST_ACK;
      ack_s2_r <= ack_s1_r;
      rd_s1_r <= I_HOST_RDATA;
      rd_s2_r <= rd_s1_r;
    end
  end

  // APB response
  // Ready is a one-cycle pulse in the access cycle.
  // The error flag travels with ready for unmapped offsets.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_PRDATA <= RST_ZERO;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= I_PSEL & ~I_PENABLE & ~mapped;
      O_PRDATA <= prdata_nxt;
    end
  end

  // Data path, address and mode
  // Starts come from command 1, a transmit write or a receive read.
  // Set of busy wins over its clear when both fall in one cycle.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      buf_r <= '0;
      addr_r <= '0;
      busy_r <= 1'b0;
      rx_mode_r <= 1'b0;
      par_ok_r <= 1'b1;
      cb1_r <= 1'b0;
      cb2_r <= 1'b0;
      st_r <= HWI_IDLE;
    end else if (I_CE) begin
      st_r <= st_nxt;
      if (ifc_clr) begin
        cb1_r <= 1'b0;
        cb2_r <= 1'b0;
      end
      // Address: clear, load, or pre-increment on each start and on command 2
      if (cmd_clr) addr_r <= '0;
      else if (wr & hit_addr) addr_r <= I_PWDATA[ADDR_W-1:0];
      else if (cmd_rx | cmd_tx | tx_go | rx_go) addr_r <= addr_r + 1'b1;
      // Buffer: cleared by commands 1 and 2 or a receive read, filled by a write or a fetch
      if (cmd_rx | cmd_tx | rx_go) buf_r <= '0;
      else if (tx_go) buf_r <= tx_word;
      else if (done & rx_mode_r) buf_r <= rd_s2_r;
      // Direction follows the last command 1 or 2, transmit write or receive read
      if (cmd_rx | rx_go) rx_mode_r <= 1'b1;
      else if (cmd_tx | tx_go) rx_mode_r <= 1'b0;
      if (done & rx_mode_r) par_ok_r <= rd_par;
      // Busy spans the whole host transfer
      if (start) busy_r <= 1'b1;
      else if (done) busy_r <= 1'b0;
    end
  end

  // Host port drive
  // Address, direction and word are latched with the request
  // and stay put until the synchronised ack is seen.
  // The program interrupt is a one-cycle pulse.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_HOST_REQ <= 1'b0;
      O_HOST_WE <= 1'b0;
      O_HOST_ADDR <= '0;
      O_HOST_WDATA <= '0;
      O_HOST_INT <= 1'b0;
    end else if (I_CE) begin
      O_HOST_INT <= cmd_int;
      if (req_go) begin
        O_HOST_REQ <= 1'b1;
        O_HOST_WE <= ~rx_mode_r;
        O_HOST_ADDR <= addr_r;
        O_HOST_WDATA <= buf_r;
      end else if (done) begin
        O_HOST_REQ <= 1'b0;
      end
    end
  end

  // Interrupt status and mask; set wins over clear
  // Bit 0 marks each finished transfer, bit 1 a fetched parity error.
  // The output is one cycle behind the status and mask.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      irq_stat_r <= (irq_stat_r & ~((wr & hit_is) ? I_PWDATA[IRQ_W-1:0] : '0)) | irq_ev;
      if (wr & hit_im) irq_mask_r <= I_PWDATA[IRQ_W-1:0];
      O_IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// ---- test/hwi_properties.sv ----
// Port checks for the host word interface
module hwi_props
  import hwi_pkg::*;
(
  input wire logic I_CORE_CLK, I_RST, I_CE, I_PSEL, I_PENABLE, I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic O_PREADY, O_PSLVERR, O_HOST_REQ, O_HOST_WE, I_HOST_ACK, O_HOST_INT,
  input wire logic [ADDR_W-1:0] O_HOST_ADDR,
  input wire logic [BUF_W-1:0] O_HOST_WDATA
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // Accepted write of a transmit word
  wire tx_go = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & (I_PADDR == OFF_TXDATA);
  property p_rdy; I_PSEL & !I_PENABLE & I_CE |=> O_PREADY; endproperty
  property p_one; O_PREADY |=> !O_PREADY; endproperty
  property p_err; O_PSLVERR |-> O_PREADY; endproperty
  property p_int; O_HOST_INT |=> !O_HOST_INT; endproperty
  property p_hold; O_HOST_REQ & !I_HOST_ACK |=> O_HOST_REQ; endproperty
  property p_stab; O_HOST_REQ & $past(O_HOST_REQ) |-> $stable(O_HOST_ADDR) && $stable(O_HOST_WDATA); endproperty
  property p_go; tx_go |-> ##[1:3] O_HOST_REQ & O_HOST_WE; endproperty
  property p_par; O_HOST_REQ & O_HOST_WE |-> ^O_HOST_WDATA && O_HOST_WDATA[CB2_POS:CB1_POS] == 2'b00; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  a_one: assert property (p_one) else $error("ready too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_int: assert property (p_int) else $error("host interrupt not a pulse");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_stab: assert property (p_stab) else $error("host word moved");
  a_go: assert property (p_go) else $error("no host write");
  a_par: assert property (p_par) else $error("bad word layout");
  // Main scenarios
  c_tx: cover property (tx_go);
  c_rx: cover property (O_HOST_REQ & !O_HOST_WE);
  c_int: cover property (O_HOST_INT);
endmodule
bind hwi_top hwi_props i_props (.*);

// ---- test/hwi_host.sv ----
// Host memory model answering word requests
module hwi_host (
  input wire logic clk, rst, req, we,
  input wire logic [17:0] addr,
  input wire logic [20:0] wdata,
  input wire logic [2:0] dly,
  output logic ack,
  output logic [20:0] rdata
);
  logic [20:0] mem [0:15];
  logic [2:0] n;
  // Answer after a delay, drop ack once the request falls
  always @(posedge clk) begin
    if (rst | !req) begin
      ack <= 0;
      n <= 0;
      rdata <= rst ? 21'h0 : ~rdata; // Released bus does not hold
    end else if (n != dly) begin
      n <= n + 1;
      rdata <= ~rdata;
    end else begin
      ack <= 1;
      if (we) mem[addr[3:0]] <= wdata;
      rdata <= mem[addr[3:0]];
    end
  end
endmodule

// ---- test/hwi_top_tb.sv ----
// Self-checking bench for the host word interface
module hwi_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hwi_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, ack, req, we, hint, rdy, err, irq, e;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, rd, q;
  logic [17:0] ha;
  logic [17:0] d [0:3];
  logic [20:0] hwd, hrd;
  logic [2:0] dly = 0;
  int fails = 0, checked = 0, seed = 32'ha6cb, nint = 0;
  always #5 clk = ~clk;
  // Count host interrupt pulses
  always @(posedge clk) if (hint === 1) nint++;
  hwi_top i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(rd), .O_PREADY(rdy), .O_PSLVERR(err),
    .O_HOST_REQ(req), .O_HOST_WE(we), .O_HOST_ADDR(ha), .O_HOST_WDATA(hwd), .I_HOST_ACK(ack),
    .I_HOST_RDATA(hrd), .O_HOST_INT(hint), .O_IRQ(irq));
  hwi_host i_host (.clk(clk), .rst(rst), .req(req), .we(we), .addr(ha), .wdata(hwd), .dly(dly),
    .ack(ack), .rdata(hrd));
  task chk(input string n, input logic [31:0] s, x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; result left in q and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1;
    pw <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk) t++; while (rdy !== 1 && t < 20);
    q = rd;
    e = err;
    psel <= 0;
    pen <= 0;
    chk("ready", t < 20, 1);
  endtask
  task poll;
    int t;
    t = 0;
    do begin
      apb(0, OFF_STATUS, 0);
      t++;
    end while (q[ST_NOT_BUSY] !== 1 && t < 60);
    chk("poll", t < 60, 1);
  endtask
  function automatic logic [31:0] word(input logic [17:0] v);
    return {11'h0, ~^v, 2'b00, v};
  endfunction
  task end_of_test;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    apb(0, OFF_STATUS, 0);
    chk("status", q, 32'h0000_0003);
    apb(0, OFF_ADDR, 0);
    chk("addr", q, 0);
    apb(0, 8'h1C, 0);
    chk("slverr", e, 1);
    apb(1, OFF_IRQ_MASK, 1);
    apb(1, OFF_CMD, 32'h0000_0011);
    apb(1, OFF_ADDR, 32'h0000_0013);
    for (int i = 0; i < 4; i++) begin
      d[i] = 18'($random(seed));
      dly <= 3'($random(seed));
      apb(1, OFF_TXDATA, {14'h0, d[i]});
      apb(0, OFF_STATUS, 0);
      chk("busy", q[ST_NOT_BUSY], 0);
      poll;
    end
    chk("irq", irq, 1);
    apb(1, OFF_IRQ_STAT, 1);
    repeat (2) @(posedge clk);
    chk("irq clr", irq, 0);
    apb(0, OFF_ADDR, 0);
    chk("addr", q, 32'h0000_0017);
    for (int c = 0; c < 9; c = (c == 0) ? 3 : c + 1) apb(1, OFF_CMD, c);
    apb(0, OFF_ADDR, 0);
    chk("addr", q, 0);
    apb(1, OFF_CMD, {28'h0, FC_HOST_INT});
    $display("Transmit and command tests done");
    apb(1, OFF_ADDR, 32'h0000_0013);
    apb(1, OFF_CMD, {28'h0, FC_RECEIVE});
    for (int i = 0; i < 3; i++) begin
      poll;
      chk("rx st", q[ST_RX_MODE:ST_PARITY_OK], 2'b11);
      apb(0, OFF_RXDATA, 0);
      chk("rx word", q, word(d[i]));
    end
    poll;
    apb(1, OFF_IRQ_MASK, 0);
    apb(1, OFF_CMD, {28'h0, FC_TRANSMIT});
    apb(0, OFF_RXDATA, 0);
    chk("rx clr", q, 0);
    chk("masked", irq, 0);
    chk("host int", nint, 1);
    $display("Receive tests done");
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, OFF_ADDR, 0);
    chk("addr rst", q, 0);
    apb(0, OFF_STATUS, 0);
    chk("status rst", q, 32'h0000_0003);
    $display("Reset test done");
    end_of_test;
  end
endmodule
